// ==== rtl/adc_ctrl_map.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 converter control block. Assumes byte addresses on a 32-bit register bus.
*/
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

`define OFS_CONTROL 8'h00
`define OFS_RES_HI 8'h04
`define OFS_RES_LO 8'h08
`define OFS_STATUS 8'h0C
`define OFS_TAD_DIV 8'h10

`define BIT_JUSTIFY 7
`define BIT_VREF 6
`define BIT_CHAN_HI 4
`define BIT_CHAN_LO 2
`define BIT_GO 1
`define BIT_ON 0
`define BIT_DONE_FLAG 0

`define CONTROL_RST 8'h00
`define TAD_DIV_RST 8'h03

`define TADS_PER_CONV 4'hB
`define TADS_AFTER_ABORT 4'h2

`endif

// ==== rtl/adc_ctrl_pkg.sv ====
/*
 Types shared by the converter control block and its sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package adc_ctrl_pkg;

   typedef enum logic [1:0] {
      seq_idle,
      seq_conv,
      seq_hold
   } seq_state_t;

   typedef enum logic [2:0] {
      reg_control,
      reg_res_hi,
      reg_res_lo,
      reg_status,
      reg_tad_div,
      reg_none
   } reg_sel_t;

endpackage

// ==== rtl/conv_if.sv ====
/*
 Link between the register side and the conversion sequencer.
 Assumes both ends run on the same clock.
*/
interface conv_if #(parameter int RES_W = 10);
   logic run;
   logic [7:0] tad_div;
   logic busy;
   logic idle;
   logic done;
   logic [RES_W-1:0] result;

   modport ctl (output run, output tad_div, input busy, input idle, input done,
      input result);
   modport seq (input run, input tad_div, output busy, output idle, output done,
      output result);
endinterface

// ==== rtl/adc_sar_sequencer.sv ====
/*
 Conversion sequencer: divides the system clock into bit periods, times a
 conversion and the hold-off after an abort, and hands over the code.
 Assumes the analog front end holds its code steady near the end of a
 conversion, so the bus-wide two-flop sampler sees a settled word.
*/
`include "adc_ctrl_map.svh"

module adc_sar_sequencer #(
   parameter int RES_W = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [RES_W-1:0] analog_code,
   conv_if.seq cv
);

   adc_ctrl_pkg::seq_state_t state_r;
   adc_ctrl_pkg::seq_state_t last_r;
   logic [7:0] div_cnt_r;
   logic [3:0] tad_cnt_r;
   logic [RES_W-1:0] code_s1_r;
   logic [RES_W-1:0] code_s2_r;
   logic [15:0] cyc_r;
   logic [15:0] cur_cyc;
   logic tick;
   logic aborting;

   assign tick = div_cnt_r == cv.tad_div;
   assign aborting = state_r == adc_ctrl_pkg::seq_conv && !cv.run;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         code_s1_r <= '0;
         code_s2_r <= '0;
      end else begin
         code_s1_r <= analog_code;
         code_s2_r <= code_s1_r;
      end
   end

   // The divider restarts on an abort so the hold-off is a full two periods.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_r <= 8'h00;
      end else if (state_r == adc_ctrl_pkg::seq_idle || tick || aborting) begin
         div_cnt_r <= 8'h00;
      end else begin
         div_cnt_r <= 8'(div_cnt_r + 8'h01);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= adc_ctrl_pkg::seq_idle;
         tad_cnt_r <= 4'h0;
      end else begin
         case (state_r)
            adc_ctrl_pkg::seq_idle: begin
               if (cv.run) begin
                  state_r <= adc_ctrl_pkg::seq_conv;
                  tad_cnt_r <= 4'h0;
               end
            end
            adc_ctrl_pkg::seq_conv: begin
               if (!cv.run) begin
                  state_r <= adc_ctrl_pkg::seq_hold;
                  tad_cnt_r <= 4'h0;
               end else if (tick) begin
                  if (tad_cnt_r == 4'(`TADS_PER_CONV - 4'h1)) begin
                     state_r <= adc_ctrl_pkg::seq_idle;
                  end
                  tad_cnt_r <= 4'(tad_cnt_r + 4'h1);
               end
            end
            adc_ctrl_pkg::seq_hold: begin
               if (tick) begin
                  if (tad_cnt_r == 4'(`TADS_AFTER_ABORT - 4'h1)) begin
                     state_r <= adc_ctrl_pkg::seq_idle;
                  end
                  tad_cnt_r <= 4'(tad_cnt_r + 4'h1);
               end
            end
            default: begin
               state_r <= adc_ctrl_pkg::seq_idle;
            end
         endcase
      end
   end

   assign cv.done = state_r == adc_ctrl_pkg::seq_conv && cv.run && tick &&
      tad_cnt_r == 4'(`TADS_PER_CONV - 4'h1);
   assign cv.busy = state_r == adc_ctrl_pkg::seq_conv;
   assign cv.idle = state_r == adc_ctrl_pkg::seq_idle;
   assign cv.result = code_s2_r;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_r <= adc_ctrl_pkg::seq_idle;
         cyc_r <= 16'h0000;
      end else begin
         last_r <= state_r;
         cyc_r <= 16'(cur_cyc + 16'h0001);
      end
   end
   assign cur_cyc = (state_r != last_r) ? 16'h0000 : cyc_r;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_conv_length: assert property (cv.done |->
      cur_cyc == 16'(16'(`TADS_PER_CONV) * (16'(cv.tad_div) + 16'h0001) - 16'h0001))
      else $error("conversion length is not eleven bit periods");
   chk_hold_length: assert property (state_r == adc_ctrl_pkg::seq_idle &&
      last_r == adc_ctrl_pkg::seq_hold |->
      $past(cur_cyc) == 16'(16'(`TADS_AFTER_ABORT) * (16'(cv.tad_div) + 16'h0001)
      - 16'h0001))
      else $error("abort hold-off is not two bit periods");
   chk_abort_holds: assert property (aborting |=> state_r == adc_ctrl_pkg::seq_hold
      ##1 !cv.done)
      else $error("abort did not enter hold-off");
   cov_abort: cover property (aborting ##1 state_r == adc_ctrl_pkg::seq_hold);

endmodule

// ==== rtl/adc_control.sv ====
/*
 Control and result formatting of a 10-bit successive-approximation
 converter, with an AHB-Lite register slave.
 Assumes a single AHB-Lite master on hclk, and an analog front end that
 delivers its code on analog_code and obeys the control outputs.
*/
// Notes on behaviour
// - Control bit 7 set gives right-justified result, clear gives left.
// - Control bit 6 picks the external reference pin, else the supply rail.
// - Channel field bits 4-2: 0-3 pins, 4 comparator ref, 5 0.6V, 6 1.2V.
// - Writing one to bit 1 starts a conversion; it reads one while busy.
// - Hardware clears bit 1 when the conversion finishes.
// - Bit 0 enables the converter; clear means off and no current.
// - Left-justified high byte holds result bits nine to two.
// - Left-justified low byte holds bits one, zero on top, zeros below.
// - Right-justified high byte holds bits nine, eight low, zeros above.
// - Right-justified low byte holds result bits seven to zero.
// - Result bytes are read-only and undefined until a conversion.
// - Control bit 5 always reads zero.
// - At completion: clear bit 1, set the flag, load results together.
// - A conversion takes eleven bit-conversion periods.
// - Clearing bit 1 mid-conversion aborts, keeps result, holds off two periods.
`include "adc_ctrl_map.svh"

module adc_control #(
   parameter int ADDR_W = 8,
   parameter int RES_W = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [RES_W-1:0] analog_code,
   output logic converter_on,
   output logic positive_ref_select,
   output logic [2:0] input_channel_field,
   output logic conversion_active,
   output logic conversion_complete_flag
);

   conv_if #(.RES_W(RES_W)) cv ();

   adc_sar_sequencer #(.RES_W(RES_W)) u_seq (
      .hclk(hclk),
      .hresetn(hresetn),
      .analog_code(analog_code),
      .cv(cv)
   );

   ////////////////////////////////////////////////////////////////////////
   function automatic adc_ctrl_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] a);
      case (a)
         ADDR_W'(`OFS_CONTROL): decode = adc_ctrl_pkg::reg_control;
         ADDR_W'(`OFS_RES_HI): decode = adc_ctrl_pkg::reg_res_hi;
         ADDR_W'(`OFS_RES_LO): decode = adc_ctrl_pkg::reg_res_lo;
         ADDR_W'(`OFS_STATUS): decode = adc_ctrl_pkg::reg_status;
         ADDR_W'(`OFS_TAD_DIV): decode = adc_ctrl_pkg::reg_tad_div;
         default: decode = adc_ctrl_pkg::reg_none;
      endcase
   endfunction

   // Both bytes come from one call so they can never mix two formats.
   function automatic logic [15:0] format_result(input logic right,
      input logic [RES_W-1:0] r);
      if (right) begin
         format_result = {6'h00, r[9:8], r[7:0]};
      end else begin
         format_result = {r[9:2], r[1:0], 6'h00};
      end
   endfunction

   logic wr_pend_r;
   logic rd_pend_r;
   logic rd_done_r;
   logic [ADDR_W-1:0] addr_r;
   logic [31:0] hrdata_r;
   logic accept;
   adc_ctrl_pkg::reg_sel_t sel;
   logic ctrl_wr;
   logic status_wr;
   logic tad_wr;
   logic res_wr;

   logic justify_r;
   logic vref_r;
   logic [2:0] chan_r;
   logic go_r;
   logic on_r;
   logic flag_r;
   logic [7:0] tad_div_r;
   logic [7:0] result_hi_r;
   logic [7:0] result_lo_r;
   logic [7:0] control_view;

   ////////////////////////////////////////////////////////////////////////
   // Reads take one wait state so that the data come from a flip-flop and
   // still see a write finished in the cycle before.
   assign accept = hsel && hready && htrans[1];
   assign sel = decode(addr_r);
   assign ctrl_wr = wr_pend_r && sel == adc_ctrl_pkg::reg_control;
   assign status_wr = wr_pend_r && sel == adc_ctrl_pkg::reg_status;
   assign tad_wr = wr_pend_r && sel == adc_ctrl_pkg::reg_tad_div;
   assign res_wr = wr_pend_r &&
      (sel == adc_ctrl_pkg::reg_res_hi || sel == adc_ctrl_pkg::reg_res_lo);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r <= '0;
      end else if (hready) begin
         wr_pend_r <= accept && hwrite;
         rd_pend_r <= accept && !hwrite;
         addr_r <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_done_r <= 1'b0;
      end else begin
         rd_done_r <= rd_pend_r && !rd_done_r;
      end
   end

   assign control_view = {justify_r, vref_r, 1'b0, chan_r, go_r, on_r};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (rd_pend_r && !rd_done_r) begin
         case (sel)
            adc_ctrl_pkg::reg_control: hrdata_r <= {24'h000000, control_view};
            adc_ctrl_pkg::reg_res_hi: hrdata_r <= {24'h000000, result_hi_r};
            adc_ctrl_pkg::reg_res_lo: hrdata_r <= {24'h000000, result_lo_r};
            adc_ctrl_pkg::reg_status: hrdata_r <= {31'h0000_0000, flag_r};
            adc_ctrl_pkg::reg_tad_div: hrdata_r <= {24'h000000, tad_div_r};
            default: hrdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign hreadyout = !(rd_pend_r && !rd_done_r);
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         justify_r <= 1'(`CONTROL_RST >> `BIT_JUSTIFY);
         vref_r <= 1'b0;
         chan_r <= 3'h0;
         on_r <= 1'b0;
      end else if (ctrl_wr) begin
         justify_r <= hwdata[`BIT_JUSTIFY];
         vref_r <= hwdata[`BIT_VREF];
         chan_r <= hwdata[`BIT_CHAN_HI:`BIT_CHAN_LO];
         on_r <= hwdata[`BIT_ON];
      end
   end

   // A start needs the enable; turning the converter off also aborts.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         go_r <= 1'b0;
      end else if (ctrl_wr) begin
         go_r <= hwdata[`BIT_GO] && hwdata[`BIT_ON];
      end else if (cv.done) begin
         go_r <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_r <= 1'b0;
      end else if (cv.done) begin
         flag_r <= 1'b1;
      end else if (status_wr && hwdata[`BIT_DONE_FLAG]) begin
         flag_r <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tad_div_r <= `TAD_DIV_RST;
      end else if (tad_wr) begin
         tad_div_r <= hwdata[7:0];
      end
   end

   // No reset: the result is undefined until the first conversion lands.
   always_ff @(posedge hclk) begin
      if (cv.done) begin
         {result_hi_r, result_lo_r} <= format_result(justify_r, cv.result);
      end
   end

   assign cv.run = go_r;
   assign cv.tad_div = tad_div_r;

   assign converter_on = on_r;
   assign positive_ref_select = vref_r;
   assign input_channel_field = chan_r;
   assign conversion_active = go_r;
   assign conversion_complete_flag = flag_r;

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_left_format: assert property (cv.done && !justify_r |=>
      result_hi_r == $past(cv.result[9:2]) &&
      result_lo_r == {$past(cv.result[1:0]), 6'h00})
      else $error("left-justified result misplaced");
   chk_right_format: assert property (cv.done && justify_r |=>
      result_hi_r == {6'h00, $past(cv.result[9:8])} &&
      result_lo_r == $past(cv.result[7:0]))
      else $error("right-justified result misplaced");
   chk_done_effects: assert property (cv.done && !ctrl_wr |=> !go_r && flag_r)
      else $error("completion did not clear start or set flag");
   chk_start_taken: assert property (ctrl_wr && hwdata[`BIT_GO] && hwdata[`BIT_ON]
      |=> go_r ##1 (!cv.idle || !go_r))
      else $error("start write did not begin a conversion");
   chk_off_no_go: assert property (!on_r && !$past(on_r) |-> !go_r && !cv.busy)
      else $error("conversion running while disabled");
   chk_results_ro: assert property (res_wr && !cv.done |=>
      $stable(result_hi_r) && $stable(result_lo_r))
      else $error("bus write altered a result byte");
   chk_abort_keeps: assert property (cv.busy && !go_r |->
      ##1 $stable(result_hi_r) [*3])
      else $error("abort changed the result");
   chk_reserved_zero: assert property (rd_pend_r && !rd_done_r &&
      sel == adc_ctrl_pkg::reg_control |=> hrdata_r[5] == 1'b0 && hreadyout)
      else $error("reserved control bit read as one");
   chk_flag_set_wins: assert property (cv.done && status_wr |=> flag_r)
      else $error("completion lost to a flag clear");

   cov_done: cover property (cv.done ##1 flag_r);
   cov_abort: cover property (cv.busy && !go_r);
   cov_read: cover property (rd_pend_r ##1 rd_done_r);

endmodule

// ==== verif/adc_control_and_result_format_test.sv ====
/*
 Self-checking bench for the converter control block: register access over
 AHB-Lite, control fields, both result layouts, abort and late format change.
 Assumes the design files under rtl/ are compiled first, and that the bench
 alone plays the bus master and the analog front end.
*/
module adc_control_and_result_format_test;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int BIT_CONVERSION_PERIOD = 4;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [9:0] analog_code = 10'h000;
   logic converter_on;
   logic positive_ref_select;
   logic [2:0] input_channel_field;
   logic conversion_active;
   logic conversion_complete_flag;
   logic [7:0] rdata;
   int n_mismatch = 0;
   int compares = 0;

   always #5 hclk = ~hclk;

   adc_control i_adc_control (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .analog_code(analog_code),
      .converter_on(converter_on),
      .positive_ref_select(positive_ref_select),
      .input_channel_field(input_channel_field),
      .conversion_active(conversion_active),
      .conversion_complete_flag(conversion_complete_flag)
   );

   ////////////////////////////////////////////////////////////////////////////

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Ready is looked at on the falling edge, where it has settled, so the
   // outcome never depends on process order at the rising edge.
   task automatic wait_ready;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      rdata = hrdata[7:0];
      @(posedge hclk);
   endtask

   task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, d};
      wait_ready;
      check({7'h00, hresp}, 8'h00, "response");
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
      @(negedge hclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      bus(a, 1'b0, 8'h00);
      check(rdata, exp, what);
   endtask

   // Counts cycles until the start/status output drops, then checks the flag.
   task automatic wait_conv(output int n);
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (conversion_active === 1'b1 && n < 300);
      check({7'h00, conversion_complete_flag}, 8'h01, "flag at completion");
   endtask

   ////////////////////////////////////////////////////////////////////////////

   task automatic t_reset;
      rd(8'h00, 8'h00, "control after reset");
      rd(8'h14, 8'h00, "unmapped read");
      check({4'h0, converter_on, input_channel_field}, 8'h00, "outputs after reset");
      $display("test reset done");
   endtask

   task automatic t_fields;
      wr(8'h00, 8'h7C);
      rd(8'h00, 8'h5C, "unused bit");
      check({7'h00, positive_ref_select}, 8'h01, "reference pin");
      check({7'h00, converter_on}, 8'h00, "converter off");
      for (int c = 0; c < 7; c++) begin
         wr(8'h00, {3'b000, c[2:0], 2'b01});
         check({5'h00, input_channel_field}, {5'h00, c[2:0]}, "channel");
         check({6'h00, positive_ref_select, converter_on}, 8'h01, "rail and on");
      end
      $display("test fields done");
   endtask

   task automatic t_conv(input logic [7:0] ctl, input logic [9:0] code, input logic [7:0] hi,
      input logic [7:0] lo);
      int n;
      analog_code <= code;
      wr(8'h00, ctl);
      repeat (4) @(posedge hclk);
      wr(8'h00, ctl | 8'h02);
      @(negedge hclk);
      check({7'h00, conversion_active}, 8'h01, "busy after start");
      wait_conv(n);
      if (n < 11 * BIT_CONVERSION_PERIOD || n > 11 * BIT_CONVERSION_PERIOD + 2) check(8'(n), 8'(11 * BIT_CONVERSION_PERIOD), "conversion length");
      rd(8'h00, ctl, "start bit cleared");
      rd(8'h04, hi, "result high");
      rd(8'h08, lo, "result low");
      wr(8'h0C, 8'h01);
      check({7'h00, conversion_complete_flag}, 8'h00, "flag cleared");
      $display("test conversion %h done", ctl);
   endtask

   task automatic t_readonly;
      wr(8'h04, 8'hFF);
      wr(8'h08, 8'h3F);
      rd(8'h04, 8'h71, "result high kept");
      rd(8'h08, 8'h80, "result low kept");
      $display("test read-only done");
   endtask

   task automatic t_abort;
      analog_code <= 10'h3FF;
      wr(8'h00, 8'h01);
      wr(8'h00, 8'h03);
      repeat (10) @(posedge hclk);
      wr(8'h00, 8'h01);
      @(negedge hclk);
      check({7'h00, conversion_active}, 8'h00, "aborted");
      repeat (60) @(posedge hclk);
      check({7'h00, conversion_complete_flag}, 8'h00, "no flag on abort");
      rd(8'h04, 8'h71, "result kept on abort");
      rd(8'h08, 8'h80, "result kept on abort");
      $display("test abort done");
   endtask

   // The layout must follow the justify bit as it stands at completion.
   task automatic t_late_format;
      int n;
      analog_code <= 10'h2B5;
      wr(8'h00, 8'h01);
      wr(8'h00, 8'h03);
      repeat (5) @(posedge hclk);
      wr(8'h00, 8'h83);
      wait_conv(n);
      rd(8'h04, 8'h02, "late format high");
      rd(8'h08, 8'hB5, "late format low");
      $display("test late format done");
   endtask

   ////////////////////////////////////////////////////////////////////////////

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #50000;
      n_mismatch++;
      $display("FAIL %0t watchdog expired", $time);
      final_report;
   end

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_fields;
      t_conv(8'h81, 10'h2B5, 8'h02, 8'hB5);
      t_conv(8'h01, 10'h1C6, 8'h71, 8'h80);
      t_readonly;
      t_abort;
      t_late_format;
      final_report;
   end
endmodule
